// [hw/tcr_cfg.svh]
// Register map, field positions and reset values of the timer register block
// Notes on behaviour
// - Each 16-bit value is two bytes: low at base, high at base plus one.
// - One 8-bit high-byte latch is shared by every 16-bit value.
// - Count value is readable and writable; a write loads the running counter.
// - A count write blocks compare matches of all units on the next clock.
// - A capture edge loads the capture value with the current count, except in the mode where capture value is the counter top.
// - Capture value can serve as the counter top in the selected mode.
// - Capture value reads return both bytes from the same moment via the latch.
// - Compare A is compared continuously; a match raises a flag and toggles output A.
// - Compare B is compared continuously; a match raises a flag and toggles output B.
// - Compare writes commit both bytes together through the shared latch.
// - Capture request needs enable bit 5, global enable and capture flag.
// - Compare B request needs enable bit 2, global enable and compare B flag.
// - Compare A request needs enable bit 1, global enable and compare A flag.
// - Overflow request needs enable bit 0, global enable and overflow flag.
// - A compare flag sets in the clock after count equals the compare value.
// - Flags clear on vector execution or on writing one to their bit.
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// ----------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------
`define TCR_IDX_MASK      10'h06f
`define TCR_IDX_COUNT     10'h084
`define TCR_IDX_CAPTURE   10'h086
`define TCR_IDX_CMP_A     10'h088
`define TCR_IDX_CMP_B     10'h08a
`define TCR_IDX_FLAGS     10'h036
`define TCR_IDX_CLEAR     10'h037
`define TCR_IDX_CTRL      10'h080
`define TCR_HIGH_OFFSET   10'h001

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCR_BIT_CAPTURE   5
`define TCR_BIT_CMP_B     2
`define TCR_BIT_CMP_A     1
`define TCR_BIT_OVERFLOW  0
`define TCR_FLAG_BITS     8'h27
`define TCR_CTRL_RUN      0
`define TCR_CTRL_RISE     1
`define TCR_CTRL_COMP_SRC 2
`define TCR_CTRL_CAP_TOP  3
`define TCR_CTRL_BITS     8'h0f

// ----------------------------------------
// Reset values and answers
// ----------------------------------------
`define TCR_RST_BYTE      8'h00
`define TCR_RST_WORD      16'h0000
`define TCR_COUNT_MAX     16'hffff
`define TCR_RESP_OKAY     2'b00
`define TCR_RESP_SLVERR   2'b10

`endif

// [hw/tcr_pkg.sv]
// Types shared by the timer register block
package tcr_pkg;
    typedef logic [7:0]  tcr_byte_t;
    typedef logic [15:0] tcr_word_t;
    typedef enum logic [1:0]
    {
        TCR_SEL_NONE = 2'b00,
        TCR_SEL_LOW  = 2'b01,
        TCR_SEL_HIGH = 2'b10
    } tcr_half_t;
endpackage : tcr_pkg

// [hw/tcr_compare_unit.sv]
// One compare channel: match flag pulse and toggling waveform output
`timescale 1ns/1ps
`default_nettype none
module tcr_compare_unit
    import tcr_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] count,
    input  wire logic [WIDTH-1:0] compare,
    input  wire logic             running,
    input  wire logic             block,
    output var  logic             match,
    output var  logic             wave
);
    logic hit;

    // ----------------------------------------
    // Match detection
    // ----------------------------------------
    assign hit = running && (count == compare) && !block;

    assign match = hit;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wave <= 1'b0;
        else if (hit)
            wave <= !wave;
    end
endmodule : tcr_compare_unit
`default_nettype wire

// [hw/tcr_irq_ctrl.sv]
// Sticky event flags, enable mask and interrupt requests
`timescale 1ns/1ps
`default_nettype none
`include "tcr_cfg.svh"
module tcr_irq_ctrl
    import tcr_pkg::*;
(
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire tcr_byte_t events,
    input  wire tcr_byte_t vector_ack,
    input  wire logic      clear_wr,
    input  wire logic      mask_wr,
    input  wire tcr_byte_t wdata,
    input  wire logic      global_irq_enable,
    output var  tcr_byte_t flags,
    output var  tcr_byte_t mask,
    output var  tcr_byte_t irq_request,
    output var  logic      irq
);
    tcr_byte_t clr;
    tcr_byte_t next_request;

    assign clr          = vector_ack | (clear_wr ? wdata : `TCR_RST_BYTE);
    assign next_request = (global_irq_enable ? (flags & mask) : `TCR_RST_BYTE);

    // ----------------------------------------
    // Flags, set wins over clear
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags <= `TCR_RST_BYTE;
        else
            flags <= ((flags & ~clr) | events) & `TCR_FLAG_BITS;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mask <= `TCR_RST_BYTE;
        else if (mask_wr)
            mask <= wdata & `TCR_FLAG_BITS;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_request <= `TCR_RST_BYTE;
            irq         <= 1'b0;
        end
        else
        begin
            irq_request <= next_request;
            irq         <= |next_request;
        end
    end
endmodule : tcr_irq_ctrl
`default_nettype wire

// [hw/tcr_timer_regs.sv]
// Top: 16-bit timer count, capture, compare registers behind AXI4-Lite
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_cfg.svh"
module tcr_timer_regs
    import tcr_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    output var  logic [31:0]           s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  capture_input_pin,
    input  wire logic                  comparator_out,
    input  wire logic                  global_irq_enable,
    input  wire tcr_byte_t             vector_ack,
    output var  logic                  waveform_out_a,
    output var  logic                  waveform_out_b,
    output var  tcr_byte_t             irq_request,
    output var  logic                  irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic                  aw_have;
    logic                  w_have;
    tcr_byte_t             w_byte;
    logic                  w_lane;
    logic                  wr_fire;
    logic                  ar_hs;
    logic                  next_aw_have;
    logic                  next_w_have;
    logic                  next_bvalid;
    logic                  next_rvalid;
    logic [9:0]            wr_idx;
    logic [9:0]            rd_idx;
    tcr_byte_t             high_latch;
    tcr_word_t             timer_count_value;
    tcr_word_t             capture_value;
    tcr_word_t             compare_a_value;
    tcr_word_t             compare_b_value;
    tcr_byte_t             ctrl;
    tcr_byte_t             flags;
    tcr_byte_t             mask;
    tcr_byte_t             events;
    logic                  count_written;
    logic                  block_match;
    logic                  running;
    logic                  cap_top_mode;
    tcr_word_t             top_value;
    logic                  at_top;
    logic                  cap_src;
    logic                  cap_prev;
    logic                  cap_edge;
    logic                  cap_event;
    logic                  ovf_event;
    logic                  match_a;
    logic                  match_b;
    tcr_half_t             wr_count;
    tcr_half_t             wr_cap;
    tcr_half_t             wr_cmp_a;
    tcr_half_t             wr_cmp_b;
    logic                  rd_hit;
    tcr_byte_t             rd_byte;
    logic                  rd_latch_load;
    tcr_byte_t             rd_latch_val;

    // ----------------------------------------
    // Address helpers
    // ----------------------------------------
    function automatic logic [9:0] word_index(input logic [ADDR_WIDTH-1:0] addr);
        word_index = addr[11:2];
    endfunction : word_index

    function automatic tcr_half_t half_of(input logic [9:0] idx, input logic [9:0] base);
        if (idx == base)
            half_of = TCR_SEL_LOW;
        else if (idx == base + `TCR_HIGH_OFFSET)
            half_of = TCR_SEL_HIGH;
        else
            half_of = TCR_SEL_NONE;
    endfunction : half_of

    function automatic tcr_word_t commit(input tcr_word_t cur, input tcr_half_t sel,
                                         input tcr_byte_t latch, input tcr_byte_t data);
        if (sel == TCR_SEL_LOW)
            commit = {latch, data};
        else
            commit = cur;
    endfunction : commit

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign wr_fire      = aw_have && w_have && !s_axi_bvalid;
    assign next_aw_have = (aw_have || (s_axi_awvalid && s_axi_awready)) && !wr_fire;
    assign next_w_have  = (w_have || (s_axi_wvalid && s_axi_wready)) && !wr_fire;
    assign next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);
    assign wr_idx       = word_index(aw_addr);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr <= '0;
            w_byte  <= `TCR_RST_BYTE;
            w_lane  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_addr <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
        end
        else
        begin
            aw_have       <= next_aw_have;
            w_have        <= next_w_have;
            s_axi_awready <= !next_aw_have && !next_bvalid && !wr_fire;
            s_axi_wready  <= !next_w_have && !next_bvalid && !wr_fire;
            s_axi_bvalid  <= next_bvalid;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_bresp <= `TCR_RESP_OKAY;
        else if (wr_fire)
            s_axi_bresp <= (wr_count != TCR_SEL_NONE || wr_cap != TCR_SEL_NONE ||
                            wr_cmp_a != TCR_SEL_NONE || wr_cmp_b != TCR_SEL_NONE ||
                            wr_idx == `TCR_IDX_MASK || wr_idx == `TCR_IDX_CLEAR ||
                            wr_idx == `TCR_IDX_CTRL || wr_idx == `TCR_IDX_FLAGS)
                           ? `TCR_RESP_OKAY : `TCR_RESP_SLVERR;
    end

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    assign wr_count = (wr_fire && w_lane) ? half_of(wr_idx, `TCR_IDX_COUNT)   : TCR_SEL_NONE;
    assign wr_cap   = (wr_fire && w_lane) ? half_of(wr_idx, `TCR_IDX_CAPTURE) : TCR_SEL_NONE;
    assign wr_cmp_a = (wr_fire && w_lane) ? half_of(wr_idx, `TCR_IDX_CMP_A)   : TCR_SEL_NONE;
    assign wr_cmp_b = (wr_fire && w_lane) ? half_of(wr_idx, `TCR_IDX_CMP_B)   : TCR_SEL_NONE;

    // ----------------------------------------
    // Shared high-byte latch
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            high_latch <= `TCR_RST_BYTE;
        else if (wr_count == TCR_SEL_HIGH || wr_cap == TCR_SEL_HIGH ||
                 wr_cmp_a == TCR_SEL_HIGH || wr_cmp_b == TCR_SEL_HIGH)
            high_latch <= w_byte;
        else if (rd_latch_load)
            high_latch <= rd_latch_val;
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl <= `TCR_RST_BYTE;
        else if (wr_fire && w_lane && wr_idx == `TCR_IDX_CTRL)
            ctrl <= w_byte & `TCR_CTRL_BITS;
    end

    assign running      = ctrl[`TCR_CTRL_RUN];
    assign cap_top_mode = ctrl[`TCR_CTRL_CAP_TOP];
    assign top_value    = cap_top_mode ? capture_value : `TCR_COUNT_MAX;
    assign at_top       = running && (timer_count_value == top_value);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_count_value <= `TCR_RST_WORD;
        else if (wr_count == TCR_SEL_LOW)
            timer_count_value <= commit(timer_count_value, wr_count, high_latch, w_byte);
        else if (at_top)
            timer_count_value <= `TCR_RST_WORD;
        else if (running)
            timer_count_value <= timer_count_value + 16'h0001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_written <= 1'b0;
        else
            count_written <= (wr_count == TCR_SEL_LOW);
    end

    assign block_match = count_written;

    // ----------------------------------------
    // Capture
    // ----------------------------------------
    assign cap_src  = ctrl[`TCR_CTRL_COMP_SRC] ? comparator_out : capture_input_pin;
    assign cap_edge = ctrl[`TCR_CTRL_RISE] ? (cap_src && !cap_prev) : (!cap_src && cap_prev);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cap_prev <= 1'b0;
        else
            cap_prev <= cap_src;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            capture_value <= `TCR_RST_WORD;
        else if (cap_edge && !cap_top_mode)
            capture_value <= timer_count_value;
        else
            capture_value <= commit(capture_value, wr_cap, high_latch, w_byte);
    end

    // ----------------------------------------
    // Compare values and units
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            compare_a_value <= `TCR_RST_WORD;
            compare_b_value <= `TCR_RST_WORD;
        end
        else
        begin
            compare_a_value <= commit(compare_a_value, wr_cmp_a, high_latch, w_byte);
            compare_b_value <= commit(compare_b_value, wr_cmp_b, high_latch, w_byte);
        end
    end

    tcr_compare_unit #(.WIDTH(16)) u_cmp_a
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .count   (timer_count_value),
        .compare (compare_a_value),
        .running (running),
        .block   (block_match),
        .match   (match_a),
        .wave    (waveform_out_a)
    );

    tcr_compare_unit #(.WIDTH(16)) u_cmp_b
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .count   (timer_count_value),
        .compare (compare_b_value),
        .running (running),
        .block   (block_match),
        .match   (match_b),
        .wave    (waveform_out_b)
    );

    // ----------------------------------------
    // Events and interrupts
    // ----------------------------------------
    assign cap_event = cap_top_mode ? at_top : cap_edge;
    assign ovf_event = at_top;

    always_comb
    begin
        events                      = `TCR_RST_BYTE;
        events[`TCR_BIT_CAPTURE]    = cap_event;
        events[`TCR_BIT_CMP_B]      = match_b;
        events[`TCR_BIT_CMP_A]      = match_a;
        events[`TCR_BIT_OVERFLOW]   = ovf_event;
    end

    tcr_irq_ctrl u_irq
    (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .events            (events),
        .vector_ack        (vector_ack),
        .clear_wr          (wr_fire && w_lane && wr_idx == `TCR_IDX_CLEAR),
        .mask_wr           (wr_fire && w_lane && wr_idx == `TCR_IDX_MASK),
        .wdata             (w_byte),
        .global_irq_enable (global_irq_enable),
        .flags             (flags),
        .mask              (mask),
        .irq_request       (irq_request),
        .irq               (irq)
    );

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign ar_hs       = s_axi_arvalid && s_axi_arready;
    assign next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
    assign rd_idx      = word_index(s_axi_araddr);

    always_comb
    begin
        rd_hit        = 1'b1;
        rd_byte       = `TCR_RST_BYTE;
        rd_latch_load = 1'b0;
        rd_latch_val  = `TCR_RST_BYTE;
        case (rd_idx)
            `TCR_IDX_COUNT:
            begin
                rd_byte       = timer_count_value[7:0];
                rd_latch_load = ar_hs;
                rd_latch_val  = timer_count_value[15:8];
            end
            `TCR_IDX_CAPTURE:
            begin
                rd_byte       = capture_value[7:0];
                rd_latch_load = ar_hs;
                rd_latch_val  = capture_value[15:8];
            end
            `TCR_IDX_CMP_A:
            begin
                rd_byte       = compare_a_value[7:0];
                rd_latch_load = ar_hs;
                rd_latch_val  = compare_a_value[15:8];
            end
            `TCR_IDX_CMP_B:
            begin
                rd_byte       = compare_b_value[7:0];
                rd_latch_load = ar_hs;
                rd_latch_val  = compare_b_value[15:8];
            end
            `TCR_IDX_COUNT + `TCR_HIGH_OFFSET,
            `TCR_IDX_CAPTURE + `TCR_HIGH_OFFSET,
            `TCR_IDX_CMP_A + `TCR_HIGH_OFFSET,
            `TCR_IDX_CMP_B + `TCR_HIGH_OFFSET:
                rd_byte = high_latch;
            `TCR_IDX_MASK:
                rd_byte = mask;
            `TCR_IDX_FLAGS:
                rd_byte = flags;
            `TCR_IDX_CTRL:
                rd_byte = ctrl;
            `TCR_IDX_CLEAR:
                rd_byte = `TCR_RST_BYTE;
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
        end
        else
        begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TCR_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? `TCR_RESP_OKAY : `TCR_RESP_SLVERR;
        end
    end
endmodule : tcr_timer_regs
`default_nettype wire

// [tb/tcr_timer_regs_properties.sv]
// Port checker of the timer register block
`timescale 1ns/1ps
`default_nettype none
module tcr_timer_regs_properties
    import tcr_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        global_irq_enable,
    input wire tcr_byte_t   irq_request,
    input wire logic        irq
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data beyond one byte");
    AST_REQ_GLOBAL: assert property (irq_request != 8'h00 |-> $past(global_irq_enable))
        else $error("request without global enable");
    AST_REQ_BITS: assert property (irq_request[7:6] == 2'b00 && irq_request[4:3] == 2'b00)
        else $error("request on unused bit");
    AST_GLOBAL_OFF: assert property (!global_irq_enable [*2] |-> !irq)
        else $error("interrupt while globally disabled");
endmodule : tcr_timer_regs_properties
bind tcr_timer_regs tcr_timer_regs_properties i_chk (.*);
`default_nettype wire

// [tb/tcr_timer_regs_tb_top.sv]
// Self-checking testbench of the timer register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tcr_timer_regs_tb_top
    import tcr_pkg::*;
;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, pin, glb, wave_a, wave_b, irq, cmp;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    tcr_byte_t   ack, req;
    int          miscompares = 0;
    int          n_compared = 0;

    tcr_timer_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_input_pin(pin), .comparator_out(cmp), .global_irq_enable(glb),
        .vector_ack(ack), .waveform_out_a(wave_a), .waveform_out_b(wave_b), .irq_request(req), .irq(irq));

    // ----------------------------------------
    // Bus tasks and scenarios
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [11:0] a, input tcr_byte_t d, input logic [1:0] e);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, e)
    endtask : wr
    task automatic rd(input logic [11:0] a, output tcr_byte_t d, input logic [1:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata[7:0];
        `CHK(rresp, e)
    endtask : rd
    task automatic rc(input logic [11:0] a, input tcr_byte_t x);
        tcr_byte_t d;
        rd(a, d, 2'b00);
        `CHK(d, x)
    endtask : rc
    task automatic wr16(input logic [11:0] a, input tcr_word_t v);
        wr(a + 12'h004, v[15:8], 2'b00);
        wr(a, v[7:0], 2'b00);
    endtask : wr16
    task automatic rc16(input logic [11:0] a, input tcr_word_t v);
        rc(a, v[7:0]);
        rc(a + 12'h004, v[15:8]);
    endtask : rc16
    task automatic t_regs;
        tcr_byte_t d;
        rc(12'h1bc, 8'h00);
        rc16(12'h220, 16'h0000);
        wr16(12'h228, 16'h1234);
        rc16(12'h228, 16'h1234);
        wr(12'h224, 8'h56, 2'b00);
        rc(12'h228, 8'h34);
        rc(12'h224, 8'h12);
        wr(12'h004, 8'h11, 2'b10);
        rd(12'h004, d, 2'b10);
    endtask : t_regs
    task automatic t_capture;
        wr(12'h200, 8'h02, 2'b00);
        wr16(12'h210, 16'habcd);
        rc16(12'h210, 16'habcd);
        pin <= 1'b1;
        cyc(4);
        rc16(12'h218, 16'habcd);
        rc(12'h0d8, 8'h20);
        wr(12'h1bc, 8'h20, 2'b00);
        glb <= 1'b1;
        cyc(3);
        `CHK(req, 8'h20)
        `CHK(irq, 1'b1)
        glb <= 1'b0;
        cyc(3);
        `CHK(irq, 1'b0)
        glb <= 1'b1;
        ack <= 8'h20;
        cyc(1);
        ack <= 8'h00;
        cyc(3);
        `CHK(irq, 1'b0)
        pin <= 1'b0;
        cyc(2);
        pin <= 1'b1;
        cyc(3);
        wr(12'h0dc, 8'h20, 2'b00);
        rc(12'h0d8, 8'h00);
    endtask : t_capture
    task automatic t_compare;
        wr(12'h1bc, 8'h07, 2'b00);
        wr16(12'h220, 16'h0004);
        wr16(12'h228, 16'h0004);
        wr16(12'h210, 16'hfff0);
        wr(12'h200, 8'h01, 2'b00);
        while (wave_a !== 1'b1)
            @(posedge aclk);
        wr(12'h200, 8'h00, 2'b00);
        `CHK(wave_b, 1'b1)
        `CHK(req, 8'h07)
        rc(12'h0d8, 8'h07);
    endtask : t_compare
    task automatic t_block;
        wr(12'h0dc, 8'h27, 2'b00);
        wr(12'h200, 8'h01, 2'b00);
        wr16(12'h210, 16'h0004);
        cyc(4);
        wr(12'h200, 8'h00, 2'b00);
        rc(12'h0d8, 8'h00);
        `CHK({wave_a, wave_b}, 2'b11)
    endtask : t_block
    task automatic t_modes;
        wr(12'h200, 8'h06, 2'b00);
        wr16(12'h210, 16'h0042);
        cmp <= 1'b1;
        cyc(2);
        rc16(12'h218, 16'h0042);
        wr16(12'h218, 16'h0003);
        wr16(12'h210, 16'h0000);
        wr(12'h0dc, 8'h27, 2'b00);
        wr(12'h200, 8'h09, 2'b00);
        cyc(8);
        wr(12'h200, 8'h00, 2'b00);
        rc(12'h0d8, 8'h21);
    endtask : t_modes
    task automatic summarize;
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial
    begin
        #250000;
        miscompares++;
        summarize;
    end
    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, pin, glb, cmp} = '0;
        {awaddr, araddr, wdata, ack} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_capture;
        t_compare;
        t_block;
        t_modes;
        summarize;
    end
endmodule : tcr_timer_regs_tb_top
`default_nettype wire
